// ---- design/llsc_pkg.sv ----
// package for the load-locked / store-conditional unit
package llsc_pkg;
    localparam int unsigned ADDR_W = 64;
    localparam int unsigned PA_W = 44;
    localparam int unsigned DISP_W = 16;
    // locked range is 2**LOCK_SHIFT bytes: 8 minimum, 128 recommended maximum
    localparam int unsigned LOCK_SHIFT = 5;
    localparam int unsigned LOCK_MIN_SHIFT = 3;
    localparam int unsigned LOCK_MAX_SHIFT = 7;
    localparam int unsigned OPS_BETWEEN_TICKS = 40;
    localparam logic LOCK_FLAG_RST = 1'b0;

    typedef enum logic [3:0] {
        LLSC_OP_NONE,
        LLSC_OP_LOAD_LONG_LOCKED,
        LLSC_OP_LOAD_QUAD_LOCKED,
        LLSC_OP_STORE_LONG_CONDITIONAL,
        LLSC_OP_STORE_QUAD_CONDITIONAL,
        LLSC_OP_STORE_LONG,
        LLSC_OP_STORE_QUAD,
        LLSC_OP_STORE_QUAD_UNALIGNED
    } llsc_op_e;

    // request from the pipeline
    typedef struct packed {
        llsc_op_e op;
        logic [ADDR_W-1:0] base_register;
        logic [DISP_W-1:0] disp;
        logic [63:0] data_register;
    } llsc_req_s;

    // memory request toward the coherent memory system
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] vaddr;
        logic [7:0] byte_en;
        logic [63:0] wdata;
    } llsc_mem_s;

    // reply from translation and memory
    typedef struct packed {
        logic [PA_W-1:0] paddr;
        logic [63:0] rdata;
        logic acc_viol;
        logic fault_write;
        logic fault_read;
        logic tnv;
        logic miss;
    } llsc_rsp_s;

    // exception report
    typedef struct packed {
        logic acc_viol;
        logic fault_write;
        logic fault_read;
        logic align;
        logic tnv;
    } llsc_exc_s;
endpackage

// ---- design/llsc_unit.sv ----
// reservation logic and store data path for locked and plain integer memory operations
`timescale 1ns/1ns
// What this block does
// R01: faultless load-locked saves physical address and sets reservation flag
// R02: load-locked address base plus signed displacement; longword result sign-extended
// R03: a foreign store inside locked range clears the flag
// R04: locked range is aligned power-of-two block, 8 bytes to one page
// R05: exception return clears flag; other calls and own accesses do not
// R06: store-conditional writes memory only while flag still set
// R07: store-conditional returns old flag in data register, then clears flag
// R08: longword conditional writes bits 31:0; quadword writes all 64 bits
// R09: flag test and store are atomic; one of two rivals wins
// R10: second store-conditional without load-locked always fails
// R11: second load-locked replaces earlier reservation
// R12: load-locked skips write check; store-conditional may raise write faults
// R13: load-locked never disturbs other processors' state
// R14: store-conditional outcome given only after point of coherency
// R15: store-conditional misses are serviced and retried, not failed
// R16: at least 40 operate instructions between timer interrupts
// R17: hardware locked range at most 128 bytes
// R18: plain stores write at computed address, alignment exception if misaligned
// R19: unaligned quad store clears low three address bits, no alignment check
// R20: stores report access, write fault, alignment, not-valid exceptions
// R21: owned block may be released on branch or memory op, failing later store
// R22: reset clears reservation flag
module llsc_unit (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire llsc_pkg::llsc_req_s req_i,
    output logic req_ready_o,
    output logic mem_valid_o,
    output llsc_pkg::llsc_mem_s mem_o,
    input wire logic mem_ready_i,
    input wire logic rsp_valid_i,
    input wire llsc_pkg::llsc_rsp_s rsp_i,
    input wire logic coherent_i,
    input wire logic snoop_store_i,
    input wire logic [llsc_pkg::PA_W-1:0] snoop_paddr_i,
    input wire logic exc_return_i,
    input wire logic release_i,
    output logic done_o,
    output logic [63:0] result_o,
    output logic result_we_o,
    output llsc_pkg::llsc_exc_s exc_o,
    output logic lock_flag_o,
    output logic [llsc_pkg::PA_W-1:0] lock_addr_o
);
    import llsc_pkg::*;

    typedef enum logic [1:0] {
        LLSC_IDLE,
        LLSC_ISSUE,
        LLSC_WAIT,
        LLSC_COMMIT
    } llsc_state_e;

    llsc_state_e state_q;
    llsc_req_s cur_q;
    logic [ADDR_W-1:0] va_q;
    logic lock_flag_q;
    logic [PA_W-1:0] lock_addr_q;
    logic sc_ok_q;
    logic sc_seen_q; // conditional reply already in
    logic done_q;
    logic [63:0] result_q;
    logic result_we_q;
    llsc_exc_s exc_q;

    logic [ADDR_W-1:0] va_d;
    logic [ADDR_W-1:0] disp_ext;
    logic is_ll;
    logic is_sc;
    logic is_long;
    logic is_unal;
    logic misalign;
    logic snoop_hit;
    logic ll_set;
    logic lock_clear;
    logic rsp_fault;

    // locked block size, held between 8 and 128 bytes whatever the package asks
    // R04: range limits
    // R17: 128-byte cap
    localparam int unsigned LOCK_BITS = (LOCK_SHIFT < LOCK_MIN_SHIFT) ? LOCK_MIN_SHIFT :
        ((LOCK_SHIFT > LOCK_MAX_SHIFT) ? LOCK_MAX_SHIFT : LOCK_SHIFT);

    // R02: effective address
    assign disp_ext = {{(ADDR_W - DISP_W){req_i.disp[DISP_W-1]}}, req_i.disp};
    // R19: unaligned form drops low three bits
    assign va_d = (req_i.op == LLSC_OP_STORE_QUAD_UNALIGNED) ?
        ((req_i.base_register + disp_ext) & ~64'h0000000000000007) :
        (req_i.base_register + disp_ext);

    // decode of the held operation
    assign is_ll = (cur_q.op == LLSC_OP_LOAD_LONG_LOCKED) || (cur_q.op == LLSC_OP_LOAD_QUAD_LOCKED);
    assign is_sc = (cur_q.op == LLSC_OP_STORE_LONG_CONDITIONAL) || (cur_q.op == LLSC_OP_STORE_QUAD_CONDITIONAL);
    assign is_long = (cur_q.op == LLSC_OP_LOAD_LONG_LOCKED) || (cur_q.op == LLSC_OP_STORE_LONG_CONDITIONAL) ||
        (cur_q.op == LLSC_OP_STORE_LONG);
    assign is_unal = (cur_q.op == LLSC_OP_STORE_QUAD_UNALIGNED);
    // R18: natural alignment check
    assign misalign = !is_unal && (is_long ? (va_q[1:0] != 2'b00) : (va_q[2:0] != 3'b000));

    // R03: foreign store into the aligned locked block
    // R13: only foreign stores are watched, own loads never broadcast
    assign snoop_hit = snoop_store_i && lock_flag_q &&
        (snoop_paddr_i[PA_W-1:LOCK_BITS] == lock_addr_q[PA_W-1:LOCK_BITS]);

    // R12: locked loads see read faults only, stores see write faults
    assign rsp_fault = rsp_i.acc_viol || rsp_i.tnv || (is_ll ? rsp_i.fault_read : rsp_i.fault_write);

    // R01: reservation set on faultless locked load
    assign ll_set = (state_q == LLSC_WAIT) && rsp_valid_i && !rsp_i.miss && !rsp_fault && is_ll;
    // R05: exception return clears
    // R21: ownership release clears
    // R07: conditional commit clears
    // R10: so the next conditional fails
    assign lock_clear = exc_return_i || release_i || snoop_hit || (state_q == LLSC_COMMIT && is_sc);

    assign req_ready_o = (state_q == LLSC_IDLE);

    // request capture
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_q <= '0;
            va_q <= '0;
        end else if (req_valid_i && req_ready_o) begin
            cur_q <= req_i;
            va_q <= va_d;
        end
    end

    // sequencing of one memory operation
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= LLSC_IDLE;
            sc_ok_q <= 1'b0;
            sc_seen_q <= 1'b0;
        end else begin
            unique case (state_q)
                // waits for a real operation, op none is ignored
                LLSC_IDLE: begin
                    sc_seen_q <= 1'b0;
                    if (req_valid_i && req_i.op != LLSC_OP_NONE) begin
                        state_q <= LLSC_ISSUE;
                    end
                end
                // holds the request until memory takes it
                LLSC_ISSUE: begin
                    if (misalign) begin
                        state_q <= LLSC_IDLE;
                    // R06: skip the write if reservation already gone
                    end else if (is_sc && !lock_flag_q) begin
                        sc_ok_q <= 1'b0;
                        state_q <= LLSC_COMMIT;
                    end else if (mem_ready_i) begin
                        state_q <= LLSC_WAIT;
                    end
                end
                // waits for the reply, and for coherency on a conditional
                LLSC_WAIT: begin
                    if (rsp_valid_i) begin
                        // R15: miss serviced, reissue
                        if (rsp_i.miss) begin
                            state_q <= LLSC_ISSUE;
                        end else if (rsp_fault) begin
                            state_q <= LLSC_IDLE;
                        end else if (is_sc) begin
                            // R14: outcome waits for coherency
                            // R09: flag sampled with the coherent grant
                            sc_ok_q <= lock_flag_q && !lock_clear;
                            sc_seen_q <= 1'b1;
                            state_q <= coherent_i ? LLSC_COMMIT : LLSC_WAIT;
                        end else begin
                            state_q <= LLSC_IDLE;
                        end
                    // reply in, coherency pending: a clear meanwhile still fails it
                    end else if (is_sc && sc_seen_q) begin
                        sc_ok_q <= sc_ok_q && !lock_clear;
                        if (coherent_i) begin
                            state_q <= LLSC_COMMIT;
                        end
                    end
                end
                // one cycle to report the conditional outcome
                LLSC_COMMIT: begin
                    state_q <= LLSC_IDLE;
                end
            endcase
        end
    end

    // memory request drive
    // R08: byte lanes by width
    // R18: plain stores at computed address
    always_comb begin
        mem_valid_o = (state_q == LLSC_ISSUE) && !misalign && !(is_sc && !lock_flag_q);
        mem_o.write = !is_ll;
        mem_o.vaddr = va_q;
        mem_o.wdata = cur_q.data_register;
        if (is_long) begin
            mem_o.byte_en = va_q[2] ? 8'hF0 : 8'h0F;
            mem_o.wdata = {cur_q.data_register[31:0], cur_q.data_register[31:0]};
        end else begin
            mem_o.byte_en = 8'hFF;
        end
    end

    // reservation flag and address
    // R11: a later locked load overwrites
    // R22: reset clears flag
    // R16: no ageing, flag waits however long the sequence runs
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lock_flag_q <= LOCK_FLAG_RST;
            lock_addr_q <= '0;
        end else if (ll_set) begin
            lock_flag_q <= 1'b1;
            lock_addr_q <= rsp_i.paddr;
        end else if (lock_clear) begin
            lock_flag_q <= 1'b0;
        end
    end

    // completion, result and exceptions
    // R20: exception reporting
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
            result_q <= '0;
            result_we_q <= 1'b0;
            exc_q <= '0;
        end else begin
            done_q <= 1'b0;
            result_we_q <= 1'b0;
            exc_q <= '0;
            if (state_q == LLSC_ISSUE && misalign) begin
                done_q <= 1'b1;
                exc_q.align <= 1'b1;
            // faulted reply: report it, leave the flag alone
            end else if (state_q == LLSC_WAIT && rsp_valid_i && !rsp_i.miss && rsp_fault) begin
                done_q <= 1'b1;
                exc_q.acc_viol <= rsp_i.acc_viol;
                exc_q.tnv <= rsp_i.tnv;
                exc_q.fault_read <= is_ll && rsp_i.fault_read;
                exc_q.fault_write <= !is_ll && rsp_i.fault_write;
            // clean reply of a load or a plain store
            end else if (state_q == LLSC_WAIT && rsp_valid_i && !rsp_i.miss && !is_sc) begin
                done_q <= 1'b1;
                // R02: sign-extend longword locked result
                if (is_ll) begin
                    result_we_q <= 1'b1;
                    result_q <= is_long ? {{32{rsp_i.rdata[31]}}, rsp_i.rdata[31:0]} : rsp_i.rdata;
                end
            end else if (state_q == LLSC_COMMIT) begin
                // R07: old flag returned as success
                done_q <= 1'b1;
                result_we_q <= 1'b1;
                result_q <= {63'h0, sc_ok_q};
            end
        end
    end

    assign done_o = done_q;
    assign result_o = result_q;
    assign result_we_o = result_we_q;
    assign exc_o = exc_q;
    assign lock_flag_o = lock_flag_q;
    assign lock_addr_o = lock_addr_q;
endmodule

// ---- verification/llsc_mem_model.sv ----
// memory and coherency partner model
`timescale 1ns/1ns
module llsc_mem_model (
    input wire logic mclk_i,
    input wire logic mem_valid_i,
    input wire llsc_pkg::llsc_mem_s mem_i,
    input wire logic slow_i,
    input wire logic miss_i,
    input wire logic fw_i,
    output llsc_pkg::llsc_rsp_s rsp_o,
    output logic mem_ready_o,
    output logic rsp_valid_o,
    output logic coherent_o
);
    import llsc_pkg::*;
    int wr_cnt = 0;
    logic missed = 0;
    llsc_mem_s last;
    // accept a request, reply two cycles later
    initial begin
        {mem_ready_o, rsp_valid_o, coherent_o} = 3'h0;
        rsp_o = '1;
        forever begin
            @(negedge mclk_i);
            if (mem_valid_i === 1'b1) begin
                repeat (slow_i ? 3 : 1) @(posedge mclk_i);
                #5 mem_ready_o = 1;
                @(negedge mclk_i);
                last = mem_i;
                @(posedge mclk_i) #5 mem_ready_o = 0;
                @(posedge mclk_i) #5 rsp_valid_o = 1;
                coherent_o = 1;
                // every other reply misses
                rsp_o = '{last.vaddr[PA_W-1:0], {32'h1234_5678, 4'hF, last.vaddr[27:0]}, 1'b0,
                    fw_i && missed, 1'b0, 1'b0, miss_i && !missed};
                missed = miss_i && !missed;
                wr_cnt += (last.write && !rsp_o.fault_write && !rsp_o.miss);
                @(posedge mclk_i) #5 rsp_valid_o = 0;
                coherent_o = 0;
                rsp_o = ~rsp_o;
            end
        end
    end
endmodule

// ---- verification/llsc_unit_assertions.sv ----
// port assertions for the reservation unit
`timescale 1ns/1ns
module llsc_unit_assertions (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic req_valid_i,
    input wire llsc_pkg::llsc_req_s req_i,
    input wire logic req_ready_o,
    input wire logic mem_valid_o,
    input wire llsc_pkg::llsc_mem_s mem_o,
    input wire logic mem_ready_i,
    input wire logic snoop_store_i,
    input wire logic [llsc_pkg::PA_W-1:0] snoop_paddr_i,
    input wire logic exc_return_i,
    input wire logic release_i,
    input wire logic done_o,
    input wire logic [63:0] result_o,
    input wire logic result_we_o,
    input wire llsc_pkg::llsc_exc_s exc_o,
    input wire logic lock_flag_o,
    input wire logic [llsc_pkg::PA_W-1:0] lock_addr_o
);
    import llsc_pkg::*;
    logic tk, mis, hit;
    logic [63:0] va;
    llsc_op_e op_q;
    // take, address, alignment and range match
    assign tk = req_valid_i && req_ready_o && req_i.op != LLSC_OP_NONE;
    assign va = req_i.base_register + {{48{req_i.disp[15]}}, req_i.disp};
    assign mis = (req_i.op inside {LLSC_OP_LOAD_LONG_LOCKED, LLSC_OP_STORE_LONG_CONDITIONAL,
        LLSC_OP_STORE_LONG}) ? |va[1:0] : |va[2:0];
    assign hit = snoop_paddr_i[PA_W-1:LOCK_SHIFT] == lock_addr_o[PA_W-1:LOCK_SHIFT];
    // operation in flight
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            op_q <= LLSC_OP_NONE;
        end else if (tk) begin
            op_q <= req_i.op;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_return_clears: assert property (exc_return_i && req_ready_o |=> !lock_flag_o)
        else $error("flag kept after return");
    chk_release_clears: assert property (release_i && req_ready_o |=> !lock_flag_o)
        else $error("flag kept after release");
    chk_snoop_clears: assert property (snoop_store_i && hit && req_ready_o |=> !lock_flag_o)
        else $error("flag kept after foreign store");
    chk_flag_steady: assert property (req_ready_o && !req_valid_i && !exc_return_i && !release_i
        && !(snoop_store_i && hit) |=> $stable(lock_flag_o)) else $error("flag changed without cause");
    chk_sc_nowrite: assert property (tk && req_i.op inside {LLSC_OP_STORE_LONG_CONDITIONAL,
        LLSC_OP_STORE_QUAD_CONDITIONAL} && !lock_flag_o && !mis |=> !mem_valid_o ##1 !mem_valid_o
        ##1 done_o && result_o == 64'h0) else $error("conditional store without flag");
    // result is a single flag bit with bits 63:1 zero, flag cleared
    chk_sc_result: assert property (done_o && result_we_o && op_q inside {LLSC_OP_STORE_LONG_CONDITIONAL,
        LLSC_OP_STORE_QUAD_CONDITIONAL} |-> result_o[63:1] == 63'h0 && !lock_flag_o) else $error("bad result");
    chk_align_exc: assert property (tk && mis && req_i.op != LLSC_OP_STORE_QUAD_UNALIGNED
        |-> ##2 done_o && exc_o.align && !result_we_o) else $error("alignment not reported");
    chk_unal_addr: assert property (mem_valid_o && op_q == LLSC_OP_STORE_QUAD_UNALIGNED
        |-> mem_o.vaddr[2:0] == 3'h0 && mem_o.byte_en == 8'hFF && !exc_o.align) else $error("bad address");
    // memory request held while stalled
    chk_req_hold: assert property (mem_valid_o && !mem_ready_i |=> mem_valid_o && $stable(mem_o))
        else $error("request dropped");
    cover property (done_o && result_we_o && result_o == 64'h1);
    cover property (snoop_store_i && hit && lock_flag_o);
    cover property (tk && req_i.op == LLSC_OP_STORE_QUAD_UNALIGNED);
    cover property (done_o && exc_o.fault_write);
endmodule
bind llsc_unit llsc_unit_assertions llsc_unit_assertions_inst (.mclk_i(mclk_i), .rst_i(rst_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .mem_valid_o(mem_valid_o),
    .mem_o(mem_o), .mem_ready_i(mem_ready_i), .snoop_store_i(snoop_store_i), .snoop_paddr_i(snoop_paddr_i),
    .exc_return_i(exc_return_i), .release_i(release_i), .done_o(done_o), .result_o(result_o),
    .result_we_o(result_we_o), .exc_o(exc_o), .lock_flag_o(lock_flag_o), .lock_addr_o(lock_addr_o));

// ---- verification/tb.sv ----
// self-checking bench for the reservation unit
`timescale 1ns/1ns
module tb;
    import llsc_pkg::*;
    logic mclk_i = 0, rst_i = 1, req_valid_i = 0, snoop_store_i = 0, exc_return_i = 0, release_i = 0;
    logic req_ready_o, mem_valid_o, mem_ready_i, rsp_valid_i, coherent_i, done_o, result_we_o, lock_flag_o;
    logic slow = 0, miss = 0, fw = 0;
    logic [63:0] result_o, rn;
    logic [69:0] e;
    logic [69:0] expq[$];
    logic [PA_W-1:0] snoop_paddr_i = '0, lock_addr_o;
    llsc_req_s req_i = '0;
    llsc_mem_s mem_o;
    llsc_rsp_s rsp_i;
    llsc_exc_s exc_o;
    int n_errors = 0, tests_run = 0;
    llsc_unit llsc_unit_inst (.mclk_i(mclk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_ready_o(req_ready_o), .mem_valid_o(mem_valid_o), .mem_o(mem_o), .mem_ready_i(mem_ready_i),
        .rsp_valid_i(rsp_valid_i), .rsp_i(rsp_i), .coherent_i(coherent_i), .snoop_store_i(snoop_store_i),
        .snoop_paddr_i(snoop_paddr_i), .exc_return_i(exc_return_i), .release_i(release_i), .done_o(done_o),
        .result_o(result_o), .result_we_o(result_we_o), .exc_o(exc_o), .lock_flag_o(lock_flag_o),
        .lock_addr_o(lock_addr_o));
    llsc_mem_model llsc_mem_model_inst (.mclk_i(mclk_i), .mem_valid_i(mem_valid_o), .mem_i(mem_o),
        .slow_i(slow), .miss_i(miss), .fw_i(fw), .rsp_o(rsp_i), .mem_ready_o(mem_ready_i),
        .rsp_valid_o(rsp_valid_i), .coherent_o(coherent_i));
    initial forever #50 mclk_i = ~mclk_i;
    task automatic chk(string nm, logic [63:0] x, logic [63:0] s);
        tests_run++;
        if (x !== s) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // one request, note its outcome, wait for done
    task automatic op(llsc_op_e o, logic [63:0] b, logic [15:0] d, logic we, logic [63:0] r, logic [4:0] x);
        int i;
        rn = {$urandom, $urandom};
        expq.push_back({we, r, x});
        @(posedge mclk_i) #5;
        req_i = '{o, b, d, rn};
        req_valid_i = 1;
        do @(negedge mclk_i); while (req_ready_o !== 1'b1);
        @(posedge mclk_i) #5 req_valid_i = 0;
        for (i = 0; i < 60 && done_o !== 1'b1; i++) @(negedge mclk_i);
        if (i == 60) chk("done", 1, 0);
    endtask
    // k 0 foreign store, 1 return, 2 release
    task automatic pulse(int k, logic [PA_W-1:0] a);
        @(posedge mclk_i) #5 snoop_paddr_i = a;
        {snoop_store_i, exc_return_i, release_i} = 3'b100 >> k;
        @(posedge mclk_i) #5 {snoop_store_i, exc_return_i, release_i} = 3'h0;
    endtask
    task automatic endt(int t, logic f, int w);
        chk("lock_flag", f, lock_flag_o);
        chk("writes", w, llsc_mem_model_inst.wr_cnt);
        $display("test %0d done", t);
    endtask
    // compare each completion with the oldest note
    always @(negedge mclk_i) begin
        if (done_o === 1'b1) begin
            e = expq.pop_front();
            chk("result_we", e[69], result_we_o);
            if (e[69])
                chk("result", e[68:5], result_o);
            chk("exc", e[4:0], exc_o);
        end
    end
    initial begin
        #500000 n_errors++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h63a2));
        repeat (16) @(posedge mclk_i);
        #5 rst_i = 0;
        op(LLSC_OP_STORE_QUAD_CONDITIONAL, 64'h1000, 16'h0, 1, 64'h0, 5'h00);
        endt(1, 0, 0);
        op(LLSC_OP_LOAD_QUAD_LOCKED, 64'h1040, 16'hFFC0, 1, 64'h1234_5678_F000_1000, 5'h00);
        chk("lock_addr", 44'h1000, lock_addr_o);
        endt(2, 1, 0);
        op(LLSC_OP_STORE_LONG_CONDITIONAL, 64'h1008, 16'h0, 1, 64'h1, 5'h00);
        chk("wdata", rn[31:0], llsc_mem_model_inst.last.wdata[31:0]);
        chk("byte_en", 8'h0F, llsc_mem_model_inst.last.byte_en);
        endt(3, 0, 1);
        op(LLSC_OP_STORE_QUAD_CONDITIONAL, 64'h1000, 16'h0, 1, 64'h0, 5'h00);
        endt(4, 0, 1);
        // replaced reservation, foreign stores outside then inside
        slow = 1;
        op(LLSC_OP_LOAD_LONG_LOCKED, 64'h1000, 16'h0, 1, 64'hFFFF_FFFF_F000_1000, 5'h00);
        op(LLSC_OP_LOAD_QUAD_LOCKED, 64'h2000, 16'h0, 1, 64'h1234_5678_F000_2000, 5'h00);
        chk("lock_addr", 44'h2000, lock_addr_o);
        pulse(0, 44'h2020);
        chk("lock_flag", 1, lock_flag_o);
        pulse(0, 44'h201F);
        slow = 0;
        endt(5, 0, 1);
        for (int k = 1; k < 3; k++) begin
            op(LLSC_OP_LOAD_QUAD_LOCKED, 64'h1000, 16'h0, 1, 64'h1234_5678_F000_1000, 5'h00);
            pulse(k, 44'h0);
            op(LLSC_OP_STORE_QUAD_CONDITIONAL, 64'h1000, 16'h0, 1, 64'h0, 5'h00);
        end
        endt(6, 0, 1);
        // plain and unaligned stores
        op(LLSC_OP_STORE_LONG, 64'h1002, 16'h0, 0, 64'h0, 5'h02);
        op(LLSC_OP_STORE_QUAD, 64'h1004, 16'h0, 0, 64'h0, 5'h02);
        op(LLSC_OP_STORE_QUAD_UNALIGNED, 64'h1005, 16'h0, 0, 64'h0, 5'h00);
        chk("vaddr", 64'h1000, llsc_mem_model_inst.last.vaddr);
        chk("wdata", rn, llsc_mem_model_inst.last.wdata);
        op(LLSC_OP_STORE_QUAD, 64'h1010, 16'hFFF8, 0, 64'h0, 5'h00);
        chk("vaddr", 64'h1008, llsc_mem_model_inst.last.vaddr);
        endt(7, 0, 3);
        // misses and write faults
        {miss, fw} = 2'b11;
        op(LLSC_OP_LOAD_QUAD_LOCKED, 64'h3000, 16'h0, 1, 64'h1234_5678_F000_3000, 5'h00);
        op(LLSC_OP_STORE_QUAD_CONDITIONAL, 64'h3000, 16'h0, 0, 64'h0, 5'h08);
        fw = 0;
        op(LLSC_OP_STORE_QUAD_CONDITIONAL, 64'h3000, 16'h0, 1, 64'h1, 5'h00);
        chk("wdata", rn, llsc_mem_model_inst.last.wdata);
        endt(8, 0, 4);
        end_of_test();
    end
endmodule
